//--- hdl/net_supervisor_regs.svh
// Register offsets, field positions, reset values and timing counts of the network supervisor
`ifndef NET_SUPERVISOR_REGS_SVH
`define NET_SUPERVISOR_REGS_SVH
`define ADDR_CTRL 4'h0
`define ADDR_WDOG 4'h1
`define ADDR_STATE 4'h2
`define ADDR_FAULT 4'h3
`define ADDR_IRQ_STATUS 4'h4
`define ADDR_IRQ_ENABLE 4'h5
`define ADDR_IRQ_CLEAR 4'h6
`define ADDR_DEBUG 4'h7
`define CTRL_NET_EN_BIT 0
`define CTRL_INPUT_ASSIGNED_BIT 1
`define CTRL_ACTION_LSB 4
`define CTRL_RESET 8'h00
`define WDOG_RESET 16'h0078
`define WDOG_UNIT_US 25000
`define CLK_PERIOD_NS 25
`define WDOG_UNIT_CYCLES ((`WDOG_UNIT_US * 1000) / `CLK_PERIOD_NS)
`define CODE_TRIP_COMM 8'h3C
`define IRQ_BUS_OFF 0
`define IRQ_WATCHDOG 1
`define IRQ_CONN_TIMEOUT 2
`define IRQ_CONN_RELEASE 3
`endif

//--- hdl/net_supervisor_pkg.sv
// Types shared by the network supervisor
package net_supervisor_pkg;
  typedef enum logic [2:0] {
    act_trip,
    act_decel_trip,
    act_hold_speed,
    act_free_run,
    act_decel_stop
  } fault_action_t;
  typedef enum logic [3:0] {
    op_stop,
    op_run,
    op_jog,
    op_coast,
    op_dc_brake,
    op_restart_match,
    op_power_fail,
    op_restart_wait,
    op_trip_saving,
    op_trip,
    op_undervoltage,
    op_autotune
  } op_state_t;
  typedef enum logic [1:0] {
    tune_running,
    tune_done,
    tune_failed
  } tune_result_t;
endpackage

//--- hdl/network_fault_state_supervisor.sv
// Network fault supervisor and operating state code encoder
//
// Overview of operation
// - Code 0 stop, 1 run, 2 jog, 3 stopped and coasting.
// - Code 4 during DC braking including its wait.
// - Frequency-matching restart: code 5 if mode 03, code 7 if mode 02.
// - Code 6 while output halted by power failure.
// - Code 8 while waiting before a frequency-matching restart.
// - Code 9 while saving trip history; trip-clear ignored then.
// - Code 10 when tripped, 11 on input under-voltage.
// - Auto-tune codes 101 to 114 running, 115 success, 116 failure.
// - Network fault trips the drive with trip code 60.
// - Fault action: trip, decel-trip, hold speed, free-run, decel-stop.
// - Watchdog times out after set period and applies the action.
// - Only watchdog time-out uses the selected action.
// - Watchdog runs only in run mode with connection enabled.
// - Connection enabled by setting or assigned input; input overrides.
// - Connection time-out: decelerate and trip.
// - Host release: decelerate and trip.
// - No network service during faults; bus-off clears only by reset input.
// - State code sits in byte 1 of produced data.
`timescale 1ns/100ps
`include "net_supervisor_regs.svh"

module network_fault_state_supervisor
  import net_supervisor_pkg::*;
#(
  parameter int WDOG_UNIT = `WDOG_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic network_enable_input,
  input wire logic trip_reset_input,
  input wire logic [3:0] op_state,
  input wire logic [1:0] restart_mode,
  input wire logic [3:0] tune_step,
  input wire logic [1:0] tune_result,
  input wire logic bus_off,
  input wire logic conn_timeout,
  input wire logic conn_release,
  input wire logic host_activity,
  input wire logic produce_req,
  output logic [7:0] produced_byte1,
  output logic produced_valid,
  output logic net_service_en,
  output logic comm_trip,
  output logic [7:0] trip_code,
  output logic [2:0] drive_action,
  output logic action_valid,
  output logic irq
);

  if (WDOG_UNIT < 1) begin : g_bad_unit
    $error("WDOG_UNIT must be at least one cycle");
  end

  // Three-stage synchronisers for the pin inputs
  logic [2:0] net_en_sync;
  logic [2:0] rs_sync;
  logic net_en_pin;
  logic rs_pin;
  logic rs_prev;
  logic [2:0] next_net_en_sync;
  logic [2:0] next_rs_sync;
  logic next_net_en_pin;
  logic next_rs_pin;

  always_comb begin
    next_net_en_sync = {net_en_sync[1:0], network_enable_input};
    next_rs_sync = {rs_sync[1:0], trip_reset_input};
    // A change counts once the last two stages agree
    next_net_en_pin = (net_en_sync[2] == net_en_sync[1]) ? net_en_sync[2] : net_en_pin;
    next_rs_pin = (rs_sync[2] == rs_sync[1]) ? rs_sync[2] : rs_pin;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      net_en_sync <= 3'h0;
      rs_sync <= 3'h0;
      net_en_pin <= 1'b0;
      rs_pin <= 1'b0;
      rs_prev <= 1'b0;
    end else begin
      net_en_sync <= next_net_en_sync;
      rs_sync <= next_rs_sync;
      net_en_pin <= next_net_en_pin;
      rs_pin <= next_rs_pin;
      rs_prev <= rs_pin;
    end
  end

  wire logic rs_rise = rs_pin && !rs_prev;

  // Software registers
  logic [7:0] ctrl;
  logic [15:0] wdog_period;
  logic [3:0] irq_status;
  logic [3:0] irq_enable;
  logic [7:0] next_ctrl;
  logic [15:0] next_wdog_period;
  logic [3:0] next_irq_status;
  logic [3:0] next_irq_enable;

  // Fault state
  logic fault_active;
  logic bus_off_latched;
  logic [15:0] wdog_units;
  logic [$clog2(WDOG_UNIT+1)-1:0] wdog_tick;
  logic next_fault_active;
  logic next_bus_off_latched;
  logic [15:0] next_wdog_units;
  logic [$clog2(WDOG_UNIT+1)-1:0] next_wdog_tick;
  logic [2:0] next_drive_action;
  logic next_action_valid;
  logic next_comm_trip;
  logic [7:0] next_trip_code;
  // Cause is registered beside the action, since fault inputs may be one-cycle pulses
  logic [3:0] fault_events;
  logic [3:0] next_fault_events;

  function automatic logic [7:0] encode_state(input logic [3:0] st, input logic [1:0] mode,
                                               input logic [3:0] step, input logic [1:0] res);
    logic [7:0] code;
    code = 8'h00;
    case (op_state_t'(st))
      op_stop: code = 8'h00;
      op_run: code = 8'h01;
      op_jog: code = 8'h02;
      op_coast: code = 8'h03;
      op_dc_brake: code = 8'h04;
      op_restart_match: code = (mode == 2'h3) ? 8'h05 : 8'h07;
      op_power_fail: code = 8'h06;
      op_restart_wait: code = 8'h08;
      op_trip_saving: code = 8'h09;
      op_trip: code = 8'h0A;
      op_undervoltage: code = 8'h0B;
      op_autotune: begin
        case (tune_result_t'(res))
          tune_done: code = 8'h73;
          tune_failed: code = 8'h74;
          default: code = 8'h65 + {4'h0, (step > 4'hD) ? 4'hD : step};
        endcase
      end
      default: code = 8'h00;
    endcase
    return code;
  endfunction

  wire logic conn_enabled = ctrl[`CTRL_INPUT_ASSIGNED_BIT] ? net_en_pin : ctrl[`CTRL_NET_EN_BIT];
  wire logic wdog_armed = (op_state_t'(op_state) == op_run) && conn_enabled && !fault_active;
  wire logic wdog_expire = wdog_armed && (wdog_units >= wdog_period) && (wdog_tick == '0) && (wdog_period != 16'h0);
  wire fault_action_t sel_action = fault_action_t'(ctrl[`CTRL_ACTION_LSB +: 3]);
  // Trip history save blocks the trip-clear
  wire logic clear_ok = rs_rise && (op_state_t'(op_state) != op_trip_saving);

  always_comb begin
    next_fault_active = fault_active;
    next_bus_off_latched = bus_off_latched;
    next_wdog_units = wdog_units;
    next_wdog_tick = wdog_tick;
    next_drive_action = drive_action;
    next_action_valid = 1'b0;
    next_comm_trip = comm_trip;
    next_trip_code = trip_code;
    next_fault_events = 4'h0;
    if (!wdog_armed || host_activity) begin
      next_wdog_units = 16'h0;
      next_wdog_tick = '0;
    end else if (wdog_tick == WDOG_UNIT[$bits(wdog_tick)-1:0] - 1'b1) begin
      next_wdog_tick = '0;
      next_wdog_units = wdog_units + 16'h1;
    end else begin
      next_wdog_tick = wdog_tick + 1'b1;
    end
    if (clear_ok) begin
      next_fault_active = 1'b0;
      next_bus_off_latched = 1'b0;
      next_comm_trip = 1'b0;
      next_trip_code = 8'h00;
    end
    // Bus-off uses the trip response, since only the watchdog takes the selection
    if (bus_off && !fault_active) begin
      next_fault_active = 1'b1;
      next_bus_off_latched = 1'b1;
      next_drive_action = act_trip;
      next_fault_events[`IRQ_BUS_OFF] = 1'b1;
      next_action_valid = 1'b1;
    end else if (wdog_expire) begin
      next_fault_active = 1'b1;
      next_drive_action = sel_action;
      next_fault_events[`IRQ_WATCHDOG] = 1'b1;
      next_action_valid = 1'b1;
    end else if ((conn_timeout || conn_release) && !fault_active) begin
      next_fault_active = 1'b1;
      next_drive_action = act_decel_trip;
      next_fault_events[`IRQ_CONN_TIMEOUT] = conn_timeout;
      next_fault_events[`IRQ_CONN_RELEASE] = conn_release;
      next_action_valid = 1'b1;
    end
    if (next_action_valid) begin
      next_comm_trip = 1'b1;
      next_trip_code = `CODE_TRIP_COMM;
      next_wdog_units = 16'h0;
      next_wdog_tick = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fault_active <= 1'b0;
      bus_off_latched <= 1'b0;
      wdog_units <= 16'h0;
      wdog_tick <= '0;
      drive_action <= 3'h0;
      action_valid <= 1'b0;
      comm_trip <= 1'b0;
      trip_code <= 8'h00;
      fault_events <= 4'h0;
    end else begin
      fault_active <= next_fault_active;
      bus_off_latched <= next_bus_off_latched;
      wdog_units <= next_wdog_units;
      wdog_tick <= next_wdog_tick;
      drive_action <= next_drive_action;
      action_valid <= next_action_valid;
      comm_trip <= next_comm_trip;
      trip_code <= next_trip_code;
      fault_events <= next_fault_events;
    end
  end

  // Produced data and service gate
  logic [7:0] next_produced_byte1;
  logic next_produced_valid;
  logic next_net_service_en;

  always_comb begin
    next_produced_byte1 = produced_byte1;
    next_produced_valid = 1'b0;
    next_net_service_en = !next_fault_active;
    if (produce_req && !fault_active) begin
      next_produced_byte1 = encode_state(op_state, restart_mode, tune_step, tune_result);
      next_produced_valid = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      produced_byte1 <= 8'h00;
      produced_valid <= 1'b0;
      net_service_en <= 1'b0;
    end else begin
      produced_byte1 <= next_produced_byte1;
      produced_valid <= next_produced_valid;
      net_service_en <= next_net_service_en;
    end
  end

  // Register bus and interrupts
  logic [15:0] next_rdata;
  logic next_irq;

  always_comb begin
    next_ctrl = ctrl;
    next_wdog_period = wdog_period;
    next_irq_enable = irq_enable;
    next_irq_status = irq_status;
    next_rdata = 16'h0000;
    if (wr) begin
      case (addr)
        `ADDR_CTRL: next_ctrl = wdata[7:0];
        `ADDR_WDOG: next_wdog_period = wdata;
        `ADDR_IRQ_ENABLE: next_irq_enable = wdata[3:0];
        `ADDR_IRQ_CLEAR: next_irq_status = irq_status & ~wdata[3:0];
        default: next_ctrl = ctrl;
      endcase
    end
    // Set wins over a clear in the same cycle
    next_irq_status = next_irq_status | fault_events;
    if (rd) begin
      case (addr)
        `ADDR_CTRL: next_rdata = {8'h00, ctrl};
        `ADDR_WDOG: next_rdata = wdog_period;
        `ADDR_STATE: next_rdata = {8'h00, encode_state(op_state, restart_mode, tune_step, tune_result)};
        `ADDR_FAULT: next_rdata = {5'h00, drive_action, trip_code[6:0], fault_active};
        `ADDR_IRQ_STATUS: next_rdata = {12'h000, irq_status};
        `ADDR_IRQ_ENABLE: next_rdata = {12'h000, irq_enable};
        `ADDR_DEBUG: next_rdata = {13'h0000, conn_enabled, bus_off_latched, comm_trip};
        default: next_rdata = 16'h0000;
      endcase
    end
    next_irq = |(next_irq_status & next_irq_enable);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= `CTRL_RESET;
      wdog_period <= `WDOG_RESET;
      irq_status <= 4'h0;
      irq_enable <= 4'h0;
      rdata <= 16'h0000;
      irq <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      wdog_period <= next_wdog_period;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      rdata <= next_rdata;
      irq <= next_irq;
    end
  end

  // Assertions
  a_trip_code_set: assert property (@(posedge clk) disable iff (rst)
    action_valid |-> comm_trip && trip_code == 8'h3C) else $error("trip code not 60");
  a_conn_decel_trip: assert property (@(posedge clk) disable iff (rst)
    $rose(fault_active) && !bus_off_latched && !$past(wdog_expire) |-> drive_action == 3'h1)
    else $error("connection fault not decel-trip");
  a_wdog_action_sel: assert property (@(posedge clk) disable iff (rst)
    wdog_expire && !bus_off |=> drive_action == $past(ctrl[6:4])) else $error("watchdog action wrong");
  a_wdog_inactive: assert property (@(posedge clk) disable iff (rst)
    !wdog_armed |=> wdog_units == 16'h0) else $error("watchdog counted while idle");
  a_bus_off_held: assert property (@(posedge clk) disable iff (rst)
    bus_off_latched && !clear_ok |=> bus_off_latched) else $error("bus-off cleared without reset");
  a_no_service: assert property (@(posedge clk) disable iff (rst)
    fault_active |-> !net_service_en) else $error("service during fault");
  a_saving_no_clear: assert property (@(posedge clk) disable iff (rst)
    fault_active && op_state == 4'h8 && !bus_off |=> fault_active) else $error("clear during save");
  a_state_run_code: assert property (@(posedge clk) disable iff (rst)
    produce_req && !fault_active && op_state == 4'h1 |=> produced_valid && produced_byte1 == 8'h01)
    else $error("run code wrong");
  a_restart_code: assert property (@(posedge clk) disable iff (rst)
    produce_req && !fault_active && op_state == 4'h5 && restart_mode == 2'h2 |=> produced_byte1 == 8'h07)
    else $error("restart code wrong");
  a_trip_state_code: assert property (@(posedge clk) disable iff (rst)
    produce_req && !fault_active && op_state == 4'h9 |=> produced_byte1 == 8'h0A)
    else $error("trip code wrong");
  a_tune_done_code: assert property (@(posedge clk) disable iff (rst)
    produce_req && !fault_active && op_state == 4'hB && tune_result == 2'h1 |=> produced_byte1 == 8'h73)
    else $error("tune done code wrong");
  // Connection faults ignore the selected action
  a_timeout_decel: assert property (@(posedge clk) disable iff (rst)
    conn_timeout && !fault_active && !bus_off && !wdog_expire |=> action_valid && drive_action == 3'h1)
    else $error("timeout not decel-trip");
  a_release_decel: assert property (@(posedge clk) disable iff (rst)
    conn_release && !fault_active && !bus_off && !wdog_expire |=> action_valid && drive_action == 3'h1)
    else $error("release not decel-trip");
  a_bus_off_trip: assert property (@(posedge clk) disable iff (rst)
    bus_off && !fault_active |=> action_valid && drive_action == 3'h0 && bus_off_latched)
    else $error("bus-off response wrong");
  a_produce_gated: assert property (@(posedge clk) disable iff (rst)
    produce_req && fault_active |=> !produced_valid) else $error("produced during fault");
  a_enable_override: assert property (@(posedge clk) disable iff (rst)
    ctrl[1] |-> conn_enabled == net_en_pin) else $error("assigned input not in control");
  a_wdog_zero_off: assert property (@(posedge clk) disable iff (rst)
    wdog_period == 16'h0 |-> !wdog_expire) else $error("watchdog expired while disabled");
  a_event_cause: assert property (@(posedge clk) disable iff (rst)
    action_valid |-> fault_events != 4'h0) else $error("fault without cause");
  a_event_status: assert property (@(posedge clk) disable iff (rst)
    |fault_events |=> (irq_status & $past(fault_events)) == $past(fault_events)) else $error("event lost");
  c_wdog_trip: cover property (@(posedge clk) disable iff (rst) wdog_expire);
  c_bus_off: cover property (@(posedge clk) disable iff (rst) $rose(bus_off_latched));
  c_release: cover property (@(posedge clk) disable iff (rst) fault_events[`IRQ_CONN_RELEASE]);
  c_produce: cover property (@(posedge clk) disable iff (rst) produced_valid);

endmodule // network_fault_state_supervisor

//--- verification/net_host_model.sv
// Network host model: polled I/O and connection release
`timescale 1ns/100ps

module net_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic poll_en,
  input wire logic release_req,
  output logic host_activity,
  output logic produce_req,
  output logic conn_release
);
  logic [1:0] cnt;
  logic rel_q;

  // Poll every fourth cycle, well inside the shortest watchdog period used
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 2'h0;
      host_activity <= 1'b0;
      produce_req <= 1'b0;
      conn_release <= 1'b0;
      rel_q <= 1'b0;
    end else begin
      cnt <= cnt + 2'h1;
      host_activity <= poll_en && cnt == 2'h0;
      produce_req <= poll_en && cnt == 2'h0;
      rel_q <= release_req;
      conn_release <= release_req && !rel_q;
    end
  end
endmodule // net_host_model

//--- verification/tb_top.sv
// Testbench of the network fault and state supervisor
`timescale 1ns/100ps
`include "net_supervisor_regs.svh"

module tb_top;
  logic clk, rst, wr, rd, network_enable_input, trip_reset_input, bus_off, conn_timeout, conn_release;
  logic host_activity, produce_req, produced_valid, net_service_en, comm_trip, action_valid, irq;
  logic poll_en, release_req;
  logic [3:0] addr, op_state, tune_step;
  logic [15:0] wdata, rdata;
  logic [1:0] restart_mode, tune_result;
  logic [7:0] produced_byte1, trip_code;
  logic [2:0] drive_action;
  int n_fail, checks;

  network_fault_state_supervisor #(.WDOG_UNIT(4)) i_network_fault_state_supervisor (.clk(clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .network_enable_input(network_enable_input),
    .trip_reset_input(trip_reset_input), .op_state(op_state), .restart_mode(restart_mode), .tune_step(tune_step),
    .tune_result(tune_result), .bus_off(bus_off), .conn_timeout(conn_timeout), .conn_release(conn_release),
    .host_activity(host_activity), .produce_req(produce_req), .produced_byte1(produced_byte1),
    .produced_valid(produced_valid), .net_service_en(net_service_en), .comm_trip(comm_trip),
    .trip_code(trip_code), .drive_action(drive_action), .action_valid(action_valid), .irq(irq));

  net_host_model i_net_host_model (.clk(clk), .rst(rst), .poll_en(poll_en), .release_req(release_req),
    .host_activity(host_activity), .produce_req(produce_req), .conn_release(conn_release));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask

  // Bounded wait for the fault response, then its companion outputs
  task automatic trip_expect(input logic [2:0] a);
    bit seen;
    seen = 0;
    for (int i = 0; i < 60 && !seen; i++) begin
      @(negedge clk);
      if (action_valid === 1'b1) seen = 1;
    end
    if (!seen) begin
      chk(16'h0000, 16'h0001);
      end_sim;
    end
    chk({13'h0, drive_action}, {13'h0, a});
    chk({8'h00, trip_code}, {8'h00, `CODE_TRIP_COMM});
    chk({15'h0, comm_trip}, 16'h0001);
    chk({15'h0, net_service_en}, 16'h0000);
  endtask

  task automatic clear_fault(input logic [3:0] o, input logic still);
    @(posedge clk);
    op_state <= o;
    trip_reset_input <= 1'b1;
    repeat (6) @(posedge clk);
    trip_reset_input <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk({15'h0, comm_trip}, {15'h0, still});
  endtask

  task automatic no_trip(input int n);
    cyc(n);
    chk({15'h0, comm_trip}, 16'h0000);
  endtask

  task automatic code(input logic [3:0] o, input logic [1:0] m, input logic [3:0] s, input logic [1:0] r,
                      input logic [7:0] c);
    @(posedge clk);
    op_state <= o;
    restart_mode <= m;
    tune_step <= s;
    tune_result <= r;
    cyc(8);
    chk({8'h00, produced_byte1}, {8'h00, c});
    rd_chk(`ADDR_STATE, {8'h00, c});
  endtask

  task automatic t_reset;
    rd_chk(`ADDR_CTRL, {8'h00, `CTRL_RESET});
    rd_chk(`ADDR_WDOG, `WDOG_RESET);
    rd_chk(4'hF, 16'h0000);
    chk({14'h0, net_service_en, irq}, 16'h0002);
    $display("test reset done");
  endtask

  task automatic t_codes;
    poll_en <= 1'b1;
    code(4'h0, 2'h0, 4'h0, 2'h0, 8'h00);
    code(4'h1, 2'h0, 4'h0, 2'h0, 8'h01);
    code(4'h2, 2'h0, 4'h0, 2'h0, 8'h02);
    code(4'h3, 2'h0, 4'h0, 2'h0, 8'h03);
    code(4'h4, 2'h0, 4'h0, 2'h0, 8'h04);
    code(4'h5, 2'h3, 4'h0, 2'h0, 8'h05);
    code(4'h5, 2'h2, 4'h0, 2'h0, 8'h07);
    code(4'h6, 2'h0, 4'h0, 2'h0, 8'h06);
    code(4'h7, 2'h0, 4'h0, 2'h0, 8'h08);
    code(4'h8, 2'h0, 4'h0, 2'h0, 8'h09);
    code(4'h9, 2'h0, 4'h0, 2'h0, 8'h0A);
    code(4'hA, 2'h0, 4'h0, 2'h0, 8'h0B);
    code(4'hB, 2'h0, 4'h0, 2'h0, 8'h65);
    code(4'hB, 2'h0, 4'hD, 2'h0, 8'h72);
    code(4'hB, 2'h0, 4'h0, 2'h1, 8'h73);
    code(4'hB, 2'h0, 4'h0, 2'h2, 8'h74);
    code(4'h0, 2'h0, 4'h0, 2'h0, 8'h00);
    poll_en <= 1'b0;
    $display("test codes done");
  endtask

  task automatic t_watchdog;
    wr_reg(`ADDR_WDOG, 16'h0003);
    for (int a = 0; a < 5; a++) begin
      wr_reg(`ADDR_CTRL, {9'h000, 3'(a), 4'h1});
      @(posedge clk);
      op_state <= 4'h1;
      trip_expect(3'(a));
      clear_fault(4'h0, 1'b0);
    end
    $display("test watchdog done");
  endtask

  task automatic t_gating;
    wr_reg(`ADDR_CTRL, 16'h0001);
    no_trip(30);
    @(posedge clk);
    op_state <= 4'h2;
    no_trip(30);
    @(posedge clk);
    op_state <= 4'h1;
    poll_en <= 1'b1;
    no_trip(40);
    @(posedge clk);
    poll_en <= 1'b0;
    trip_expect(3'h0);
    clear_fault(4'h1, 1'b0);
    wr_reg(`ADDR_CTRL, 16'h0000);
    no_trip(30);
    // Input assigned but low overrides the enable setting
    wr_reg(`ADDR_CTRL, 16'h0003);
    no_trip(30);
    @(posedge clk);
    network_enable_input <= 1'b1;
    trip_expect(3'h0);
    clear_fault(4'h0, 1'b0);
    network_enable_input <= 1'b0;
    $display("test gating done");
  endtask

  task automatic t_conn;
    int n;
    wr_reg(`ADDR_CTRL, 16'h0020);
    @(posedge clk);
    op_state <= 4'h1;
    conn_timeout <= 1'b1;
    @(posedge clk);
    conn_timeout <= 1'b0;
    trip_expect(3'h1);
    @(posedge clk);
    conn_timeout <= 1'b1;
    poll_en <= 1'b1;
    @(posedge clk);
    conn_timeout <= 1'b0;
    n = 0;
    repeat (12) begin
      @(negedge clk);
      n += int'(action_valid | produced_valid);
    end
    chk(16'(n), 16'h0000);
    poll_en <= 1'b0;
    clear_fault(4'h1, 1'b0);
    @(posedge clk);
    release_req <= 1'b1;
    trip_expect(3'h1);
    release_req <= 1'b0;
    clear_fault(4'h0, 1'b0);
    @(posedge clk);
    bus_off <= 1'b1;
    @(posedge clk);
    bus_off <= 1'b0;
    trip_expect(3'h0);
    rd_chk(`ADDR_FAULT, {5'h00, 3'h0, 7'(`CODE_TRIP_COMM), 1'b1});
    rd_chk(`ADDR_DEBUG, 16'h0003);
    clear_fault(4'h8, 1'b1);
    clear_fault(4'h0, 1'b0);
    $display("test conn done");
  endtask

  task automatic t_irq;
    wr_reg(`ADDR_IRQ_CLEAR, 16'h000F);
    wr_reg(`ADDR_IRQ_ENABLE, 16'h000F);
    rd_chk(`ADDR_IRQ_STATUS, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    @(posedge clk);
    conn_timeout <= 1'b1;
    @(posedge clk);
    conn_timeout <= 1'b0;
    trip_expect(3'h1);
    cyc(2);
    chk({15'h0, irq}, 16'h0001);
    rd_chk(`ADDR_IRQ_STATUS, 16'h0001 << `IRQ_CONN_TIMEOUT);
    wr_reg(`ADDR_IRQ_ENABLE, 16'h0000);
    cyc(2);
    chk({15'h0, irq}, 16'h0000);
    wr_reg(`ADDR_IRQ_ENABLE, 16'h000F);
    wr_reg(`ADDR_IRQ_CLEAR, 16'h000F);
    cyc(2);
    rd_chk(`ADDR_IRQ_STATUS, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    clear_fault(4'h0, 1'b0);
    $display("test irq done");
  endtask

  initial begin
    {rst, wr, rd, network_enable_input, trip_reset_input, bus_off, conn_timeout, poll_en, release_req} = 9'h1FF;
    {wr, rd, network_enable_input, trip_reset_input, bus_off, conn_timeout, poll_en, release_req} = 8'h00;
    {addr, op_state, tune_step, wdata, restart_mode, tune_result} = 32'h0;
    n_fail = 0;
    checks = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    t_reset();
    t_codes();
    t_watchdog();
    t_gating();
    t_conn();
    t_irq();
    end_sim();
  end
endmodule // tb_top
